// ---- verilog/ptmr_pkg.sv ----
/*
 * Shared constants, register map, field layout and carrier types for the
 * paired 16/32-bit timer. Assumes a 16-bit register port with a 4-bit word
 * address, one clock and a synchronous active-high reset.
 */
package ptmr_pkg;

	typedef logic [15:0] ptmr_word_t;
	typedef logic [3:0] ptmr_addr_t;
	typedef logic [2:0] ptmr_prio_t;

	// ----------------------------------------------------------------
	// Register offsets (word addresses)
	// ----------------------------------------------------------------
	localparam ptmr_addr_t ADDR_LO_CTRL = 4'h0;
	localparam ptmr_addr_t ADDR_HI_CTRL = 4'h1;
	localparam ptmr_addr_t ADDR_LO_COUNT = 4'h2;
	localparam ptmr_addr_t ADDR_HI_COUNT = 4'h3;
	localparam ptmr_addr_t ADDR_LO_PERIOD = 4'h4;
	localparam ptmr_addr_t ADDR_HI_PERIOD = 4'h5;
	localparam ptmr_addr_t ADDR_IRQ_STATUS = 4'h6;
	localparam ptmr_addr_t ADDR_IRQ_ENABLE = 4'h7;
	localparam ptmr_addr_t ADDR_IRQ_PRIO = 4'h8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 15;
	localparam int CTRL_IDLE_BIT = 13;
	localparam int CTRL_GATE_BIT = 6;
	localparam int CTRL_PS_LSB = 4;
	localparam int CTRL_JOIN_BIT = 3;
	localparam int CTRL_CS_BIT = 1;
	localparam int IRQ_LO_BIT = 0;
	localparam int IRQ_HI_BIT = 1;
	localparam int PRIO_LO_LSB = 0;
	localparam int PRIO_HI_LSB = 4;

	// ----------------------------------------------------------------
	// Reset values and prescaler terminal counts (1:1, 1:8, 1:64, 1:256)
	// ----------------------------------------------------------------
	localparam ptmr_word_t CTRL_RST = 16'h0000;
	localparam ptmr_word_t COUNT_RST = 16'h0000;
	localparam ptmr_word_t PERIOD_RST = 16'hffff;
	localparam logic [1:0] IRQ_BITS_RST = 2'h0;
	localparam ptmr_prio_t PRIO_RST = 3'h0;
	localparam ptmr_prio_t PRIO_OFF = 3'h0;
	localparam logic [7:0] PS_TC_DIV1 = 8'h00;
	localparam logic [7:0] PS_TC_DIV8 = 8'h07;
	localparam logic [7:0] PS_TC_DIV64 = 8'h3f;
	localparam logic [7:0] PS_TC_DIV256 = 8'hff;

	typedef struct packed {
		logic run_control;
		logic idle_stop_select;
		logic gate_count_select;
		logic [1:0] prescale_ratio;
		logic pair_join_select;
		logic clock_source_select;
	} ptmr_ctrl_s;

	function automatic ptmr_ctrl_s ptmr_ctrl_unpack(input ptmr_word_t w);
		ptmr_ctrl_s c;
		c.run_control = w[CTRL_RUN_BIT];
		c.idle_stop_select = w[CTRL_IDLE_BIT];
		c.gate_count_select = w[CTRL_GATE_BIT];
		c.prescale_ratio = w[CTRL_PS_LSB +: 2];
		c.pair_join_select = w[CTRL_JOIN_BIT];
		c.clock_source_select = w[CTRL_CS_BIT];
		return c;
	endfunction

	function automatic ptmr_word_t ptmr_ctrl_pack(input ptmr_ctrl_s c);
		ptmr_word_t w;
		w = 16'h0000;
		w[CTRL_RUN_BIT] = c.run_control;
		w[CTRL_IDLE_BIT] = c.idle_stop_select;
		w[CTRL_GATE_BIT] = c.gate_count_select;
		w[CTRL_PS_LSB +: 2] = c.prescale_ratio;
		w[CTRL_JOIN_BIT] = c.pair_join_select;
		w[CTRL_CS_BIT] = c.clock_source_select;
		return w;
	endfunction

endpackage

// ---- verilog/ptmr_pair.sv ----
/*
 * Paired 16-bit timers that run alone or join into one 32-bit timer, with
 * prescaler, gating, count pins, sticky interrupts, priority and DMA trigger.
 * Assumes MCLK is the instruction-cycle clock and the count pins are asynchronous.
 */
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module ptmr_pair #(
	parameter bit DMA_CAPABLE = 1'b1
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire ptmr_pkg::ptmr_addr_t ADDR,
	input wire ptmr_pkg::ptmr_word_t WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output ptmr_pkg::ptmr_word_t RDATA,
	input wire logic [1:0] EXT_COUNT_CLK_PIN,
	input wire logic IDLE,
	output logic IRQ,
	output ptmr_pkg::ptmr_prio_t IRQ_PRIO,
	output logic [1:0] DMA_REQ
);
	import ptmr_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ptmr_ctrl_s ctrl_reg [2];
	ptmr_word_t count_reg [2];
	ptmr_word_t count_next [2];
	ptmr_word_t period_reg [2];
	logic [7:0] pre_reg [2];
	logic [7:0] pre_next [2];
	logic [2:0] pin_sync_reg [2];
	logic [1:0] pin_lvl_reg;
	logic [1:0] pin_prev_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_en_reg;
	ptmr_prio_t prio_reg [2];
	ptmr_word_t rdata_reg;
	ptmr_prio_t irq_prio_reg;
	logic [1:0] dma_reg;
	logic [1:0] tick;
	logic [1:0] irq_evt;
	logic [1:0] irq_pend;
	logic join_on;
	ptmr_word_t rd_word;
	ptmr_prio_t best_prio;
	logic [31:0] count32;
	logic [31:0] sum32;

	function automatic logic [7:0] ps_terminal(input logic [1:0] ps);
		logic [7:0] tc;
		tc = PS_TC_DIV1;
		unique case (ps)
			2'h0: tc = PS_TC_DIV1;
			2'h1: tc = PS_TC_DIV8;
			2'h2: tc = PS_TC_DIV64;
			2'h3: tc = PS_TC_DIV256;
		endcase
		return tc;
	endfunction

	function automatic logic wr_hit(input ptmr_addr_t a);
		return WR_STB && (ADDR == a);
	endfunction

	assign join_on = ctrl_reg[0].pair_join_select;
	assign count32 = {count_reg[1], count_reg[0]};
	assign sum32 = count32 + 32'h0000_0001;

	// ------------------------------------------------------------
	// Count pin synchronisers: stages two and three must agree, filtering glitches
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		for (int i = 0; i < 2; i++) begin
			if (SRST) begin
				pin_sync_reg[i] <= 3'h0;
			end else begin
				pin_sync_reg[i] <= {pin_sync_reg[i][1:0], EXT_COUNT_CLK_PIN[i]};
			end
		end
	end

	always_ff @(posedge MCLK) begin
		for (int i = 0; i < 2; i++) begin
			if (SRST) begin
				pin_lvl_reg[i] <= 1'b0;
				pin_prev_reg[i] <= 1'b0;
			end else begin
				if (pin_sync_reg[i][1] == pin_sync_reg[i][2]) begin
					pin_lvl_reg[i] <= pin_sync_reg[i][2];
				end
				pin_prev_reg[i] <= pin_lvl_reg[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Tick source, gating and prescaler
	// ------------------------------------------------------------
	always_comb begin
		ptmr_ctrl_s cfg;
		logic src_tick;
		logic active;
		logic pre_done;
		int src;
		cfg = ctrl_reg[0];
		src_tick = 1'b0;
		active = 1'b0;
		pre_done = 1'b0;
		src = 0;
		for (int i = 0; i < 2; i++) begin
			// Joined, the lower control word steers both halves
			cfg = join_on ? ctrl_reg[0] : ctrl_reg[i];
			src = join_on ? 0 : i;
			// The upper idle-stop bit is still honoured when joined
			active = cfg.run_control
				&& !(IDLE && (cfg.idle_stop_select
				|| (join_on && ctrl_reg[1].idle_stop_select)))
				&& !(join_on && (i == 1));
			if (cfg.clock_source_select) begin
				src_tick = pin_lvl_reg[src] && !pin_prev_reg[src];
			end else if (cfg.gate_count_select) begin
				src_tick = pin_lvl_reg[src];
			end else begin
				src_tick = 1'b1;
			end
			pre_done = (pre_reg[i] == ps_terminal(cfg.prescale_ratio));
			tick[i] = active && src_tick && pre_done;
			if (!active) begin
				pre_next[i] = 8'h00;
			end else if (src_tick) begin
				pre_next[i] = pre_done ? 8'h00 : pre_reg[i] + 8'h01;
			end else begin
				pre_next[i] = pre_reg[i];
			end
		end
	end

	always_ff @(posedge MCLK) begin
		for (int i = 0; i < 2; i++) begin
			if (SRST) begin
				pre_reg[i] <= 8'h00;
			end else begin
				pre_reg[i] <= pre_next[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Counters and period match
	// ------------------------------------------------------------
	always_comb begin
		count_next[0] = count_reg[0];
		count_next[1] = count_reg[1];
		irq_evt = 2'h0;
		if (join_on) begin
			if (tick[0]) begin
				if (count32 == {period_reg[1], period_reg[0]}) begin
					count_next[0] = COUNT_RST;
					count_next[1] = COUNT_RST;
					irq_evt[IRQ_HI_BIT] = 1'b1;
				end else begin
					count_next[0] = sum32[15:0];
					count_next[1] = sum32[31:16];
				end
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (tick[i]) begin
					if (count_reg[i] == period_reg[i]) begin
						count_next[i] = COUNT_RST;
						irq_evt[i] = 1'b1;
					end else begin
						count_next[i] = count_reg[i] + 16'h0001;
					end
				end
			end
		end
		// A software write to a count word wins over the tick in that cycle
		if (wr_hit(ADDR_LO_COUNT)) begin
			count_next[0] = WDATA;
		end
		if (wr_hit(ADDR_HI_COUNT)) begin
			count_next[1] = WDATA;
		end
	end

	always_ff @(posedge MCLK) begin
		for (int i = 0; i < 2; i++) begin
			if (SRST) begin
				count_reg[i] <= COUNT_RST;
			end else begin
				count_reg[i] <= count_next[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Control and period registers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ctrl_reg[0] <= ptmr_ctrl_unpack(CTRL_RST);
			ctrl_reg[1] <= ptmr_ctrl_unpack(CTRL_RST);
		end else begin
			if (wr_hit(ADDR_LO_CTRL)) begin
				ctrl_reg[0] <= ptmr_ctrl_unpack(WDATA);
			end
			if (wr_hit(ADDR_HI_CTRL)) begin
				// Only the lower timer can lead a pair, so the join bit is absent here
				ctrl_reg[1] <= ptmr_ctrl_unpack(WDATA & ~(16'h0001 << CTRL_JOIN_BIT));
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			period_reg[0] <= PERIOD_RST;
			period_reg[1] <= PERIOD_RST;
		end else begin
			if (wr_hit(ADDR_LO_PERIOD)) begin
				period_reg[0] <= WDATA;
			end
			if (wr_hit(ADDR_HI_PERIOD)) begin
				period_reg[1] <= WDATA;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, enable and priority
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			irq_stat_reg <= IRQ_BITS_RST;
		end else begin
			// Set wins over a write-one-to-clear in the same cycle
			irq_stat_reg <= (irq_stat_reg
				& ~(wr_hit(ADDR_IRQ_STATUS) ? WDATA[1:0] : 2'h0)) | irq_evt;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			irq_en_reg <= IRQ_BITS_RST;
			prio_reg[0] <= PRIO_RST;
			prio_reg[1] <= PRIO_RST;
		end else begin
			if (wr_hit(ADDR_IRQ_ENABLE)) begin
				irq_en_reg <= WDATA[1:0];
			end
			if (wr_hit(ADDR_IRQ_PRIO)) begin
				prio_reg[0] <= WDATA[PRIO_LO_LSB +: 3];
				prio_reg[1] <= WDATA[PRIO_HI_LSB +: 3];
			end
		end
	end

	always_comb begin
		best_prio = PRIO_OFF;
		for (int i = 0; i < 2; i++) begin
			irq_pend[i] = irq_stat_reg[i] && irq_en_reg[i]
				&& (prio_reg[i] != PRIO_OFF);
		end
		// Lower interrupt bits are ignored while joined
		if (join_on) begin
			irq_pend[IRQ_LO_BIT] = 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			if (irq_pend[i] && (prio_reg[i] > best_prio)) begin
				best_prio = prio_reg[i];
			end
		end
	end

	assign IRQ = |irq_pend;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			irq_prio_reg <= PRIO_OFF;
			dma_reg <= 2'h0;
		end else begin
			irq_prio_reg <= best_prio;
			dma_reg <= DMA_CAPABLE ? irq_evt : 2'h0;
		end
	end

	assign IRQ_PRIO = irq_prio_reg;
	assign DMA_REQ = dma_reg;

	// ------------------------------------------------------------
	// Register read port: data valid only in the cycle after the strobe
	// ------------------------------------------------------------
	always_comb begin
		rd_word = 16'h0000;
		unique case (ADDR)
			ADDR_LO_CTRL: rd_word = ptmr_ctrl_pack(ctrl_reg[0]);
			ADDR_HI_CTRL: rd_word = ptmr_ctrl_pack(ctrl_reg[1]);
			ADDR_LO_COUNT: rd_word = count_reg[0];
			ADDR_HI_COUNT: rd_word = count_reg[1];
			ADDR_LO_PERIOD: rd_word = period_reg[0];
			ADDR_HI_PERIOD: rd_word = period_reg[1];
			ADDR_IRQ_STATUS: rd_word = {14'h0000, irq_stat_reg};
			ADDR_IRQ_ENABLE: rd_word = {14'h0000, irq_en_reg};
			ADDR_IRQ_PRIO: rd_word = {9'h000, prio_reg[1], 1'b0, prio_reg[0]};
			default: rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= RD_STB ? rd_word : 16'h0000;
		end
	end

	assign RDATA = rdata_reg;
endmodule

// ---- sim/ptmr_pair_properties.sv ----
/*
 * Port checker for the paired timer, bound to every instance.
 * Assumes the map, reset values and output timing of ptmr_pkg.
 */
`timescale 1ns/100ps
module ptmr_pair_chk
	import ptmr_pkg::*;
#(
	parameter bit DMA_CAPABLE = 1'b1
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire ptmr_pkg::ptmr_addr_t ADDR,
	input wire ptmr_pkg::ptmr_word_t WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire ptmr_pkg::ptmr_word_t RDATA,
	input wire logic [1:0] EXT_COUNT_CLK_PIN,
	input wire logic IDLE,
	input wire logic IRQ,
	input wire ptmr_pkg::ptmr_prio_t IRQ_PRIO,
	input wire logic [1:0] DMA_REQ
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	reset_outputs_a: assert property ($fell(SRST) |-> RDATA == 16'h0000 && !IRQ &&
		IRQ_PRIO == PRIO_OFF && DMA_REQ == 2'h0) else $error("outputs busy after reset");
	rdata_quiet_a: assert property (!RD_STB |=> RDATA == 16'h0000)
		else $error("read data outside read slot");
	prio_pending_a: assert property (IRQ |=> IRQ_PRIO != PRIO_OFF)
		else $error("pending source with zero rank");
	prio_none_a: assert property (!IRQ |=> IRQ_PRIO == PRIO_OFF)
		else $error("rank shown with nothing pending");
	hi_join_zero_a: assert property (RD_STB && ADDR == ADDR_HI_CTRL |=>
		!RDATA[CTRL_JOIN_BIT]) else $error("upper join bit reads one");
	status_read_a: assert property (IRQ && RD_STB && ADDR == ADDR_IRQ_STATUS |=>
		RDATA[1:0] != 2'h0) else $error("interrupt without status bit");
	enable_echo_a: assert property (WR_STB && ADDR == ADDR_IRQ_ENABLE ##1
		RD_STB && ADDR == ADDR_IRQ_ENABLE |=> RDATA[1:0] == $past(WDATA[1:0], 2))
		else $error("enable readback wrong");
	period_echo_a: assert property (WR_STB && ADDR == ADDR_HI_PERIOD ##1
		RD_STB && ADDR == ADDR_HI_PERIOD |=> RDATA == $past(WDATA, 2))
		else $error("period readback wrong");
	dma_off_a: assert property (DMA_CAPABLE == 1'b0 |-> DMA_REQ == 2'h0)
		else $error("transfer trigger from incapable pair");
endmodule

bind ptmr_pair ptmr_pair_chk #(.DMA_CAPABLE(DMA_CAPABLE)) chk_i (.MCLK(MCLK), .SRST(SRST),
	.ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
	.EXT_COUNT_CLK_PIN(EXT_COUNT_CLK_PIN), .IDLE(IDLE), .IRQ(IRQ), .IRQ_PRIO(IRQ_PRIO),
	.DMA_REQ(DMA_REQ));

// ---- sim/ptmr_pin_model.sv ----
/*
 * Far side of the count pins: a gate level or a slow burst of count edges.
 * Assumes both timer pins may share one waveform.
 */
`timescale 1ns/100ps
module ptmr_pin_model (
	output logic [1:0] pin
);
	// Pins rest low outside bursts, as a real source would
	initial pin = 2'h0;

	task automatic level(input logic l);
		pin = {2{l}};
	endtask

	// Odd half period walks the edges across the bench clock phase
	task automatic burst(input int c);
		repeat (c) begin
			#173 pin = 2'h3;
			#173 pin = 2'h0;
		end
	endtask
endmodule

// ---- sim/ptmr_pair_bench.sv ----
/*
 * Self-checking bench: register port, prescaler, modes, joined operation.
 * Assumes the checker is bound to ptmr_pair and the pin model drives the pins.
 */
`timescale 1ns/100ps
module ptmr_pair_bench;
	import ptmr_pkg::*;
	typedef struct {
		logic [1:0] ps;
		ptmr_word_t per;
		int gap;
	} ptmr_row_s;
	ptmr_row_s rows[4] = '{'{2'h0, 16'h0003, 4}, '{2'h1, 16'h0001, 16},
		'{2'h2, 16'h0000, 64}, '{2'h3, 16'h0000, 256}};
	logic mclk, srst, wr_stb, rd_stb, idle, irq;
	ptmr_addr_t addr;
	ptmr_word_t wdata, rdata, v;
	ptmr_prio_t prio;
	logic [1:0] pin, dma, dma2;
	int errors = 0;
	int checks = 0;
	int n;

	ptmr_pair dut (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
		.RD_STB(rd_stb), .RDATA(rdata), .EXT_COUNT_CLK_PIN(pin), .IDLE(idle), .IRQ(irq),
		.IRQ_PRIO(prio), .DMA_REQ(dma));
	ptmr_pair #(.DMA_CAPABLE(1'b0)) dut2 (.MCLK(mclk), .SRST(srst), .ADDR(addr),
		.WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(), .EXT_COUNT_CLK_PIN(pin),
		.IDLE(idle), .IRQ(), .IRQ_PRIO(), .DMA_REQ(dma2));
	ptmr_pin_model pin_m (.pin(pin));

	// ------
	// Bus and check tasks
	// ------
	task automatic tick(input int c);
		repeat (c) begin
			@(posedge mclk);
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
		end
		#1;
	endtask

	// Strobe stays up until the next task, so writes may run back to back
	task automatic wr(input ptmr_addr_t a, input ptmr_word_t d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		rd_stb <= 1'b0;
	endtask

	task automatic rd(input ptmr_addr_t a);
		@(posedge mclk);
		addr <= a;
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk(input string s, input ptmr_word_t e, input ptmr_word_t g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic gap(output int c);
		int k;
		k = 0;
		c = 0;
		while (dma[0] !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
		do begin
			tick(1);
			c++;
		end while (dma[0] !== 1'b1 && c < 300);
	endtask

	task automatic complete_run;
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		complete_run();
	end

	// ------
	// Sequence
	// ------
	initial begin
		srst = 1'b1;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		idle = 1'b0;
		addr = ADDR_LO_CTRL;
		wdata = 16'h0000;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		rd(ADDR_LO_CTRL);
		chk("lo_ctrl", CTRL_RST, v);
		rd(ADDR_LO_PERIOD);
		chk("lo_period", PERIOD_RST, v);
		rd(4'h9);
		chk("unmapped", 16'h0000, v);
		foreach (rows[i]) begin
			wr(ADDR_LO_CTRL, CTRL_RST);
			wr(ADDR_LO_PERIOD, rows[i].per);
			wr(ADDR_LO_COUNT, COUNT_RST);
			wr(ADDR_LO_CTRL, 16'h8000 | {10'h000, rows[i].ps, 4'h0});
			tick(1);
			gap(n);
			chk("gap", 16'(rows[i].gap), 16'(n));
			chk("dma_off", 16'h0000, {14'h0000, dma2});
		end
		wr(ADDR_IRQ_ENABLE, 16'h0001);
		rd(ADDR_IRQ_ENABLE);
		chk("enable", 16'h0001, v);
		chk("rank_zero", 16'h0000, 16'(irq));
		wr(ADDR_IRQ_PRIO, 16'h0005);
		tick(2);
		chk("irq_on", 16'h0001, 16'(irq));
		chk("rank", 16'h0005, 16'(prio));
		wr(ADDR_LO_CTRL, CTRL_RST);
		wr(ADDR_LO_PERIOD, PERIOD_RST);
		wr(ADDR_LO_COUNT, COUNT_RST);
		wr(ADDR_LO_CTRL, 16'h8040);
		tick(20);
		rd(ADDR_LO_COUNT);
		chk("gate_low", 16'h0000, v);
		pin_m.level(1'b1);
		tick(20);
		pin_m.level(1'b0);
		tick(10);
		rd(ADDR_LO_COUNT);
		// Filter delays both gate edges alike, so 20 high cycles give 20 counts
		chk("gate_high", 16'h0014, v);
		wr(ADDR_LO_CTRL, CTRL_RST);
		wr(ADDR_LO_COUNT, COUNT_RST);
		wr(ADDR_LO_CTRL, 16'h8042);
		tick(2);
		pin_m.burst(5);
		tick(10);
		rd(ADDR_LO_COUNT);
		chk("sync_count", 16'h0005, v);
		wr(ADDR_LO_CTRL, CTRL_RST);
		wr(ADDR_IRQ_ENABLE, 16'h0003);
		wr(ADDR_IRQ_PRIO, 16'h0075);
		wr(ADDR_IRQ_STATUS, 16'h0003);
		wr(ADDR_HI_PERIOD, 16'h0001);
		rd(ADDR_HI_PERIOD);
		chk("hi_period", 16'h0001, v);
		wr(ADDR_LO_COUNT, 16'hfffe);
		wr(ADDR_HI_COUNT, COUNT_RST);
		wr(ADDR_HI_CTRL, 16'h204a);
		rd(ADDR_HI_CTRL);
		chk("hi_ctrl", 16'h2042, v);
		@(posedge mclk);
		idle <= 1'b1;
		wr(ADDR_LO_CTRL, 16'h8008);
		tick(5);
		rd(ADDR_LO_COUNT);
		chk("idle_stop", 16'hfffe, v);
		@(posedge mclk);
		idle <= 1'b0;
		tick(8);
		rd(ADDR_HI_COUNT);
		chk("carry", 16'h0001, v);
		chk("no_match", 16'h0000, 16'(irq));
		wr(ADDR_LO_COUNT, 16'hfffd);
		n = 0;
		while (irq !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		chk("dma_joined", 16'h0002, {14'h0000, dma});
		tick(1);
		chk("irq_joined", 16'h0001, 16'(irq));
		chk("rank_joined", 16'h0007, 16'(prio));
		rd(ADDR_IRQ_STATUS);
		chk("status", 16'h0002, v);
		wr(ADDR_IRQ_ENABLE, 16'h0001);
		tick(1);
		chk("masked", 16'h0000, 16'(irq));
		wr(ADDR_IRQ_STATUS, 16'h0002);
		rd(ADDR_IRQ_STATUS);
		chk("cleared", 16'h0000, v);
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rd(ADDR_HI_PERIOD);
		chk("period_reset", PERIOD_RST, v);
		complete_run();
	end
endmodule
